// >>> cidgc_bank.sv
// indirectly addressed caller-id gain and hysteresis configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "cidgc_defines.svh"

module cidgc_bank (
  input  wire logic                        clk,                      // core clock, 250 MHz
  input  wire logic                        rst_n,                    // async reset, active low
  input  wire logic [7:0]                  gain_write_data,          // data register contents
  input  wire logic [7:0]                  gain_write_select_commit, // select and commit register
  input  wire logic                        caller_id_global_enable,  // software global enable
  input  wire logic                        fsk_decoder_enable,       // software fsk enable
  input  wire logic                        alert_detector_enable,    // software alert enable
  input  wire logic                        dual_tone_enable,         // software dual-tone enable
  input  wire logic                        high_group_energy,        // high band energy seen
  input  wire logic                        low_group_energy,         // low band energy seen
  output var  cidgc_pkg::cidgc_dtmf_cfg_type dtmf_cfg,               // tolerance and mode
  output var  cidgc_pkg::cidgc_gain_type   gain_cfg,                 // four gain stage codes
  output var  cidgc_pkg::cidgc_hyst_type   hyst_cfg,                 // four hysteresis codes
  output var  cidgc_pkg::cidgc_enables_type enables,                 // gated block enables
  output logic                             gain_code_invalid,        // a gain nibble above 10
  output logic                             high_group_tone_seen,     // tone mode presence, high
  output logic                             low_group_tone_seen       // tone mode presence, low
);
  import cidgc_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_sync1_ff;
  logic rst_sync2_ff;
  logic rst_n_int;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign rst_n_int = rst_sync2_ff;

  // ----------------------------------------------------------------
  // commit edge detection
  // ----------------------------------------------------------------
  // commit bit is from same-clock cpu logic, so no synchroniser
  logic       commit_q_ff;
  logic       commit_pulse;
  logic [2:0] sel;

  assign sel          = gain_write_select_commit[`CIDGC_SEL_MSB:`CIDGC_SEL_LSB];
  assign commit_pulse = gain_write_select_commit[`CIDGC_COMMIT_BIT] & ~commit_q_ff;

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      commit_q_ff <= 1'b0;
    end else begin
      commit_q_ff <= gain_write_select_commit[`CIDGC_COMMIT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // internal register file
  // ----------------------------------------------------------------
  // no documented reset value; zero picks the tightest tolerances
  logic [7:0] regs_ff [0:5];

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      for (int i = 0; i < 6; i++) begin
        regs_ff[i] <= `CIDGC_REG_RESET;
      end
    end else if (commit_pulse) begin
      if (sel <= `CIDGC_SEL_HYS_FL) begin
        regs_ff[sel] <= gain_write_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // field decode to registered outputs
  // ----------------------------------------------------------------
  function automatic logic gain_bad(input logic [7:0] v);
    gain_bad = (v[7:4] > `CIDGC_GAIN_MAX) || (v[3:0] > `CIDGC_GAIN_MAX);
  endfunction

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      dtmf_cfg          <= '0;
      gain_cfg          <= '0;
      hyst_cfg          <= '0;
      gain_code_invalid <= 1'b0;
    end else begin
      // upper row nibble reserved, so only the low nibble is used
      dtmf_cfg.row_tol            <= regs_ff[`CIDGC_SEL_ROW][3:0];
      dtmf_cfg.col_tol            <= regs_ff[`CIDGC_SEL_COL][3:0];
      dtmf_cfg.tone_det_mode      <= regs_ff[`CIDGC_SEL_COL][`CIDGC_MODE_BIT];
      dtmf_cfg.pt_clear_on_change <= regs_ff[`CIDGC_SEL_COL][`CIDGC_PT_CLR_BIT];
      dtmf_cfg.at_pause_on_tone   <= regs_ff[`CIDGC_SEL_COL][`CIDGC_AT_PAUSE_BIT];
      gain_cfg.alert_gain         <= regs_ff[`CIDGC_SEL_PGA_AF][7:4];
      gain_cfg.fsk_gain           <= regs_ff[`CIDGC_SEL_PGA_AF][3:0];
      gain_cfg.dtmf_gain_hi       <= regs_ff[`CIDGC_SEL_PGA_DT][7:4];
      gain_cfg.dtmf_gain_lo       <= regs_ff[`CIDGC_SEL_PGA_DT][3:0];
      gain_code_invalid           <= gain_bad(regs_ff[`CIDGC_SEL_PGA_AF]) |
                                     gain_bad(regs_ff[`CIDGC_SEL_PGA_DT]);
      hyst_cfg.alert_hysteresis_level      <= regs_ff[`CIDGC_SEL_HYS_AD][7:4];
      hyst_cfg.dual_tone_hysteresis_level  <= regs_ff[`CIDGC_SEL_HYS_AD][3:0];
      hyst_cfg.fsk_hysteresis_level        <= regs_ff[`CIDGC_SEL_HYS_FL][7:4];
      hyst_cfg.fsk_detect_hysteresis_level <= regs_ff[`CIDGC_SEL_HYS_FL][3:0];
    end
  end

  // ----------------------------------------------------------------
  // enable gating
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      enables <= '0;
    end else begin
      enables.fsk_decoder        <= caller_id_global_enable & fsk_decoder_enable;
      enables.alert_detector     <= caller_id_global_enable & alert_detector_enable;
      enables.dual_tone_receiver <= caller_id_global_enable & dual_tone_enable;
      enables.ring_detector      <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // tone presence, band energy from analog side
  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  logic [2:0] hi_sync_ff;
  logic [2:0] lo_sync_ff;
  logic       tone_on;

  assign tone_on = dtmf_cfg.tone_det_mode & enables.dual_tone_receiver;

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      hi_sync_ff <= 3'h0;
      lo_sync_ff <= 3'h0;
    end else begin
      hi_sync_ff <= {hi_sync_ff[1:0], high_group_energy};
      lo_sync_ff <= {lo_sync_ff[1:0], low_group_energy};
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      high_group_tone_seen <= 1'b0;
      low_group_tone_seen  <= 1'b0;
    end else begin
      if (!tone_on) begin
        high_group_tone_seen <= 1'b0;
      end else if (hi_sync_ff[1] == hi_sync_ff[2]) begin
        high_group_tone_seen <= hi_sync_ff[2];
      end
      if (!tone_on) begin
        low_group_tone_seen <= 1'b0;
      end else if (lo_sync_ff[1] == lo_sync_ff[2]) begin
        low_group_tone_seen <= lo_sync_ff[2];
      end
    end
  end

endmodule
`default_nettype wire

// >>> cidgc_bank_properties.sv
// port checks for the caller-id gain configuration bank
`timescale 1ns/1ps
`default_nettype none
module cidgc_bank_properties (
  input wire logic                         clk,                      // core clock
  input wire logic                         rst_n,                    // async reset
  input wire logic [7:0]                   gain_write_data,          // data value
  input wire logic [7:0]                   gain_write_select_commit, // select, commit
  input wire logic                         caller_id_global_enable,  // global gate
  input wire cidgc_pkg::cidgc_dtmf_cfg_type dtmf_cfg,                // tolerance, mode
  input wire cidgc_pkg::cidgc_gain_type    gain_cfg,                 // gain codes
  input wire cidgc_pkg::cidgc_hyst_type    hyst_cfg,                 // hysteresis codes
  input wire cidgc_pkg::cidgc_enables_type enables,                  // gated enables
  input wire logic                         gain_code_invalid         // bad gain nibble
);
  import cidgc_pkg::*;
  logic [2:0] s;
  logic       c;
  logic [2:0] up_ff;
  assign s = gain_write_select_commit[2:0];
  assign c = gain_write_select_commit[4];
  // ---------------------------------------------
  // cycles since reset, internal copy lags rst_n
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_row_write: assert property (
    $rose(c) && s == 3'h0 |-> ##2 dtmf_cfg.row_tol == $past(gain_write_data[3:0], 2))
    else $error("row tolerance not written");
  chk_col_write: assert property (
    $rose(c) && s == 3'h1 |-> ##2 dtmf_cfg[6:0] == $past({gain_write_data[3:0],
    gain_write_data[4], gain_write_data[5], gain_write_data[6]}, 2))
    else $error("column and mode not written");
  chk_gain_write: assert property (
    $rose(c) && s[2:1] == 2'h1 |-> ##2
    $past(gain_write_data, 2) == ($past(s[0], 2) ? gain_cfg[7:0] : gain_cfg[15:8]))
    else $error("gain pair not written");
  chk_hyst_write: assert property (
    $rose(c) && s[2:1] == 2'h2 |-> ##2
    $past(gain_write_data, 2) == ($past(s[0], 2) ? hyst_cfg[7:0] : hyst_cfg[15:8]))
    else $error("hysteresis pair not written");
  chk_high_select: assert property (
    $rose(c) && s[2:1] == 2'h3 |-> ##2 $stable({dtmf_cfg, gain_cfg, hyst_cfg}))
    else $error("select six or seven changed a register");
  chk_single_write: assert property (
    !$rose(c) |-> ##2 $stable({dtmf_cfg, gain_cfg, hyst_cfg}))
    else $error("register changed without commit edge");
  chk_gain_invalid: assert property (
    $stable(gain_cfg) [*3] |-> gain_code_invalid == (gain_cfg[15:12] > 4'hA ||
    gain_cfg[11:8] > 4'hA || gain_cfg[7:4] > 4'hA || gain_cfg[3:0] > 4'hA))
    else $error("gain range flag wrong");
  chk_global_gate: assert property (
    up_ff == 3'h7 && !$past(caller_id_global_enable) |-> enables[3:1] == 3'h0)
    else $error("block enabled while global enable low");
  chk_ring_active: assert property (
    up_ff == 3'h7 |-> enables.ring_detector) else $error("ring detector off");
endmodule
bind cidgc_bank cidgc_bank_properties cidgc_bank_properties_i (.clk(clk), .rst_n(rst_n),
  .gain_write_data(gain_write_data), .gain_write_select_commit(gain_write_select_commit),
  .caller_id_global_enable(caller_id_global_enable), .dtmf_cfg(dtmf_cfg),
  .gain_cfg(gain_cfg), .hyst_cfg(hyst_cfg), .enables(enables),
  .gain_code_invalid(gain_code_invalid));
`default_nettype wire

// >>> cidgc_bank_tb_top.sv
// self-checking bench for the caller-id gain configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("unexpected %0t value mismatch", $time); end end
module cidgc_bank_tb_top;
  import cidgc_pkg::*;
  logic               clk, rst_n, ge, fe, ae, de, hi, lo, inval, hseen, lseen;
  logic [7:0]         wd, sel;
  logic [7:0]         r [0:5];
  int                 fail_count, tests_run;
  cidgc_dtmf_cfg_type dtmf_cfg;
  cidgc_gain_type     gain_cfg;
  cidgc_hyst_type     hyst_cfg;
  cidgc_enables_type  enables;
  localparam logic [7:0] sug [0:5] = '{8'h01, 8'h71, 8'h99, 8'hA7, 8'h35, 8'h33};
  cidgc_bank cidgc_bank_i (.clk(clk), .rst_n(rst_n), .gain_write_data(wd),
    .gain_write_select_commit(sel), .caller_id_global_enable(ge), .fsk_decoder_enable(fe),
    .alert_detector_enable(ae), .dual_tone_enable(de), .high_group_energy(hi),
    .low_group_energy(lo), .dtmf_cfg(dtmf_cfg), .gain_cfg(gain_cfg), .hyst_cfg(hyst_cfg),
    .enables(enables), .gain_code_invalid(inval), .high_group_tone_seen(hseen),
    .low_group_tone_seen(lseen));
  always #2 clk = ~clk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_all;
    logic [15:0] g;
    logic        m;
    g = {r[2], r[3]};
    m = r[1][4] & ge & de;
    `CHK(dtmf_cfg, {r[0][3:0], r[1][3:0], r[1][4], r[1][5], r[1][6]})
    `CHK(gain_cfg, g)
    `CHK(hyst_cfg, {r[4], r[5]})
    `CHK(inval, g[15:12] > 4'hA || g[11:8] > 4'hA || g[7:4] > 4'hA || g[3:0] > 4'hA)
    `CHK(enables, {ge & fe, ge & ae, ge & de, 1'h1})
    `CHK({hseen, lseen}, {m & hi, m & lo})
  endtask
  // data moves while commit is held, so a late capture shows up
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sel <= {5'h00, a};
    wd <= d;
    @(posedge clk);
    sel[4] <= 1'h1;
    @(posedge clk);
    wd <= ~d;
    @(posedge clk);
    sel[4] <= 1'h0;
    if (a < 3'h6) r[a] = d;
    repeat (5) @(posedge clk);
    #1 chk_all();
  endtask
  // ---------------------------------------------
  // stimulus
  // ---------------------------------------------
  initial begin
    {clk, rst_n, ge, fe, ae, de, hi, lo} = 8'h3C; // no flag to clear in this block
    wd = 8'h00;
    sel = 8'h00;
    foreach (r[k]) r[k] = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    #1 chk_all();
    for (int i = 0; i < 6; i++) wr(i[2:0], sug[i]);
    for (int i = 0; i < 16; i++) wr(3'h2, {2{i[3:0]}});
    for (int i = 0; i < 64; i++) begin
      wr(i[2:0], i[2:0] == 3'h0 ? 8'(i * 8'h25) & 8'h0F : 8'(i * 8'h25));
    end
    wr(3'h1, 8'h10);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      {ge, fe, ae, de, hi} <= i[4:0];
      lo <= ~i[0];
      repeat (6) @(posedge clk);
      #1 chk_all();
    end
    @(posedge clk);
    {ge, de, hi, lo} <= 4'hF;
    wr(3'h1, 8'h00);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> cidgc_defines.svh
// constants for the caller-id gain configuration bank
// Behaviour
// - low three select bits choose which internal register takes the commit
// - rising edge of select bit 4 copies write data into the chosen register
// - six internal addresses: row, column/mode, two gains, two hysteresis pairs
// - row tolerance low nibble picks accepted row frequency error
// - column tolerance low nibble picks accepted column frequency error
// - column bit 4 selects digit decoder or simple tone detector mode
// - column bit 5 makes a frequency change clear the presence counter
// - column bit 6 makes the absence counter pause instead of count down
// - each gain nibble sets one of four gain stages, valid 0 to 10
// - hysteresis nibbles set four input buffer thresholds
// - global enable gates fsk, alert and dual-tone paths; ring detector stays on
// - in tone-detector mode with dual-tone enabled, group presence bits rise four clocks after in-band energy, once sync stages two and three agree
`ifndef CIDGC_DEFINES_SVH
`define CIDGC_DEFINES_SVH

`define CIDGC_SEL_ROW      3'h0
`define CIDGC_SEL_COL      3'h1
`define CIDGC_SEL_PGA_AF   3'h2
`define CIDGC_SEL_PGA_DT   3'h3
`define CIDGC_SEL_HYS_AD   3'h4
`define CIDGC_SEL_HYS_FL   3'h5
`define CIDGC_SEL_LSB      0
`define CIDGC_SEL_MSB      2
`define CIDGC_COMMIT_BIT   4
`define CIDGC_MODE_BIT     4
`define CIDGC_PT_CLR_BIT   5
`define CIDGC_AT_PAUSE_BIT 6
`define CIDGC_REG_RESET    8'h00
`define CIDGC_GAIN_MAX     4'hA

`endif

// >>> cidgc_pkg.sv
// types for the caller-id gain configuration bank
package cidgc_pkg;

  typedef struct packed {
    logic [3:0] row_tol;
    logic [3:0] col_tol;
    logic       tone_det_mode;
    logic       pt_clear_on_change;
    logic       at_pause_on_tone;
  } cidgc_dtmf_cfg_type;

  typedef struct packed {
    logic [3:0] alert_gain;
    logic [3:0] fsk_gain;
    logic [3:0] dtmf_gain_hi;
    logic [3:0] dtmf_gain_lo;
  } cidgc_gain_type;

  typedef struct packed {
    logic [3:0] alert_hysteresis_level;
    logic [3:0] dual_tone_hysteresis_level;
    logic [3:0] fsk_hysteresis_level;
    logic [3:0] fsk_detect_hysteresis_level;
  } cidgc_hyst_type;

  typedef struct packed {
    logic fsk_decoder;
    logic alert_detector;
    logic dual_tone_receiver;
    logic ring_detector;
  } cidgc_enables_type;

endpackage
